// >>> core/sebi_top.sv
// The address map and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
// Function
// RL1: Write-protect pin low with lock bit set freezes the protect size bits.
// RL2: Master holds write-protect at a steady level through every write instruction.
// RL3: Instructions, addresses and input data arrive most significant bit first.
// RL4: First input bit is taken on the first rising clock after select falls.
// RL5: Read output goes MSB first, from the first falling edge after instruction.
// RL6: Output is undriven whenever the device is not selected.
// RL7: Both clock modes work: sample on rising, change output on falling edges.
// RL8: Master idles the clock low in mode 0 and high in mode 3.
// RL9: Nothing is accepted while power-on reset is active.
// RL10: Reset leaves device deselected, standby, latch and busy clear, nonvolatile bits kept.
// RL11: Selection needs a seen falling select edge; select low at power-up ignored.
// RL12: Master keeps device deselected and idle before the supply falls.
// RL13: Select low means selected and active.
// RL14: Select high deselects; standby waits for any running write cycle.
// RL15: Pause freezes the bit position so the transfer resumes where it stopped.
// RL16: Master only pauses while select is low.
// RL17: While paused the output is undriven and clock and data are ignored.
// RL18: Deselect while paused resets the interface but keeps latch and busy flags.
// RL19: A complete write command still starts its write cycle on paused deselect.
// RL20: Pause begins only when pause input falls while the clock is low.
// RL21: Pause ends when pause input is high while the clock is low.
// RL22: An instruction executes only if select rises right after its last bit.
// RL23: An unknown instruction code makes the device ignore everything until deselect.
module sebi_top #(
  parameter int WRITE_CYCLES = 1000
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  input wire logic spi_hold_n,
  input wire logic spi_wp_n,
  output logic spi_miso,
  output logic spi_miso_oe,
  output logic standby
);
  import sebi_pkg::*;

  function automatic logic [7:0] status_byte(input logic lock, input logic hi, input logic lo,
                                             input logic write_enable_latch, input logic write_busy_flag);
    logic [7:0] sb;
    sb = 8'h00;
    sb[SR_STATUS_WRITE_LOCK_BIT] = lock;
    sb[SR_BP1] = hi;
    sb[SR_BP0] = lo;
    sb[SR_WEL] = write_enable_latch;
    sb[SR_WIP] = write_busy_flag;
    return sb;
  endfunction

  logic [PIN_W-1:0] pin_s;
  logic sclk_p_q, cs_p_q, hold_p_q;
  logic sclk_rise, sclk_fall, cs_rise, cs_fall, hold_fall;

  // Pins are asynchronous to aclk; the link clock is sampled, not used as a clock
  sebi_sync #(.W(PIN_W), .RST_VAL(PIN_RESET)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .din({spi_wp_n, spi_hold_n, spi_mosi, spi_cs_n, spi_sclk}),
    .dout(pin_s)
  );

  assign sclk_rise = pin_s[PIN_SCLK] && !sclk_p_q;
  assign sclk_fall = !pin_s[PIN_SCLK] && sclk_p_q;
  assign cs_rise = pin_s[PIN_CS] && !cs_p_q;
  assign cs_fall = !pin_s[PIN_CS] && cs_p_q;
  assign hold_fall = !pin_s[PIN_HOLD] && hold_p_q;

  // Serial side state
  sebi_state_t state_q, state_d;
  logic sel_q, sel_d, armed_q, armed_d, paused_q, paused_d;
  logic [2:0] bit_q, bit_d;
  logic [7:0] shift_q, shift_d, opcode_q, opcode_d, data_q, data_d, nbytes_q, nbytes_d;
  logic [15:0] addr_q, addr_d;
  logic abyte_q, abyte_d;
  logic write_enable_latch_q, write_enable_latch_d, write_busy_flag_q, write_busy_flag_d;
  logic status_write_lock_bit_q = NV_INIT;
  logic protect_size_hi_q = NV_INIT;
  logic protect_size_lo_q = NV_INIT;
  logic status_write_lock_bit_d, protect_size_hi_d, protect_size_lo_d;
  logic [WC_W-1:0] wcnt_q, wcnt_d;
  logic [31:0] lastwr_q, lastwr_d;
  logic miso_q, miso_d, miso_oe_q, miso_oe_d, standby_q, standby_d;
  logic [7:0] rd_byte_q, rd_byte_d;
  logic [7:0] byte_in, out_byte;
  logic locked, write_ok;

  assign locked = !pin_s[PIN_WP] && status_write_lock_bit_q; // [RL1]
  assign byte_in = {shift_q[6:0], pin_s[PIN_MOSI]}; // [RL3]
  assign out_byte = (opcode_q == OP_RDSR) ? status_byte(status_write_lock_bit_q, protect_size_hi_q,
                    protect_size_lo_q, write_enable_latch_q, write_busy_flag_q) : rd_byte_q;
  assign write_ok = (state_q == ST_DATA) && (opcode_q == OP_WRITE) && (nbytes_q != 8'h00)
                    && (bit_q == BIT_FIRST);

  always_comb begin
    state_d = state_q;
    sel_d = sel_q;
    armed_d = armed_q;
    paused_d = paused_q;
    bit_d = bit_q;
    shift_d = shift_q;
    opcode_d = opcode_q;
    data_d = data_q;
    nbytes_d = nbytes_q;
    addr_d = addr_q;
    abyte_d = abyte_q;
    write_enable_latch_d = write_enable_latch_q;
    write_busy_flag_d = write_busy_flag_q;
    status_write_lock_bit_d = status_write_lock_bit_q;
    protect_size_hi_d = protect_size_hi_q;
    protect_size_lo_d = protect_size_lo_q;
    wcnt_d = wcnt_q;
    lastwr_d = lastwr_q;
    miso_d = miso_q;
    if (pin_s[PIN_CS]) begin
      armed_d = 1'b1; // [RL11]
    end
    if (write_busy_flag_q) begin
      if (wcnt_q <= WC_W'(1)) begin
        write_busy_flag_d = 1'b0;
        write_enable_latch_d = 1'b0;
        wcnt_d = '0;
      end else begin
        wcnt_d = wcnt_q - WC_W'(1);
      end
    end
    if (sel_q && cs_rise) begin
      // Deselect always drops the interface; a paused one only keeps a finished write
      if (write_ok && write_enable_latch_q && !write_busy_flag_q) begin // [RL19] [RL22]
        write_busy_flag_d = 1'b1;
        wcnt_d = WC_W'(WRITE_CYCLES);
        lastwr_d = {nbytes_q, data_q, addr_q};
      end else if (!paused_q && state_q == ST_EXEC) begin // [RL22] [RL18]
        case (opcode_q)
          OP_WREN: write_enable_latch_d = 1'b1;
          OP_WRDI: write_enable_latch_d = 1'b0;
          OP_WRSR: begin
            if (write_enable_latch_q && !write_busy_flag_q && !locked) begin // [RL1]
              status_write_lock_bit_d = data_q[SR_STATUS_WRITE_LOCK_BIT];
              protect_size_hi_d = data_q[SR_BP1];
              protect_size_lo_d = data_q[SR_BP0];
              write_busy_flag_d = 1'b1;
              wcnt_d = WC_W'(WRITE_CYCLES);
            end
          end
          default: ;
        endcase
      end
      sel_d = 1'b0; // [RL14]
      paused_d = 1'b0;
      state_d = ST_IDLE;
      bit_d = BIT_FIRST;
      nbytes_d = 8'h00;
      abyte_d = 1'b0;
    end else if (!sel_q) begin
      if (cs_fall && armed_q) begin
        sel_d = 1'b1; // [RL13] [RL11]
        state_d = ST_OPCODE;
        bit_d = BIT_FIRST;
      end
    end else if (paused_q) begin
      if (pin_s[PIN_HOLD] && !pin_s[PIN_SCLK]) begin
        paused_d = 1'b0; // [RL21]
      end
    end else if (hold_fall && !pin_s[PIN_SCLK]) begin
      paused_d = 1'b1; // [RL20] [RL15]
    end else begin
      if (sclk_rise) begin // [RL7]
        if (state_q == ST_EXEC) begin
          state_d = ST_IGNORE; // [RL22]
        end else if (state_q != ST_IGNORE) begin
          shift_d = byte_in; // [RL4]
          bit_d = bit_q + 3'h1;
          if (bit_q == BIT_LAST) begin
            case (state_q)
              ST_OPCODE: begin
                opcode_d = byte_in;
                case (byte_in)
                  OP_WREN, OP_WRDI: state_d = ST_EXEC;
                  OP_WRSR: state_d = ST_DATA;
                  OP_RDSR: state_d = ST_SEND;
                  OP_READ, OP_WRITE: state_d = ST_ADDR;
                  default: state_d = ST_IGNORE; // [RL23]
                endcase
              end
              ST_ADDR: begin
                addr_d = {addr_q[7:0], byte_in};
                abyte_d = !abyte_q;
                if (abyte_q) begin
                  state_d = (opcode_q == OP_READ) ? ST_SEND : ST_DATA;
                end
              end
              ST_DATA: begin
                data_d = byte_in;
                nbytes_d = nbytes_q + 8'h01;
                if (opcode_q == OP_WRSR) begin
                  state_d = ST_EXEC;
                end
              end
              ST_SEND: begin
                if (opcode_q == OP_READ) begin
                  addr_d = addr_q + 16'h0001;
                end
              end
              default: ;
            endcase
          end
        end
      end
      if (sclk_fall && state_q == ST_SEND) begin
        miso_d = out_byte[BIT_LAST - bit_q]; // [RL5] [RL7]
      end
    end
    miso_oe_d = sel_d && !paused_d && (state_d == ST_SEND); // [RL6] [RL17]
    standby_d = !sel_d && !write_busy_flag_d; // [RL14]
  end

  always_ff @(posedge aclk) begin
    // Nonvolatile bits survive power-on reset
    status_write_lock_bit_q <= status_write_lock_bit_d; // [RL10]
    protect_size_hi_q <= protect_size_hi_d;
    protect_size_lo_q <= protect_size_lo_d;
    if (!aresetn) begin // [RL9] [RL10]
      state_q <= ST_IDLE;
      sel_q <= 1'b0;
      armed_q <= 1'b0;
      paused_q <= 1'b0;
      bit_q <= BIT_FIRST;
      shift_q <= 8'h00;
      opcode_q <= 8'h00;
      data_q <= 8'h00;
      nbytes_q <= 8'h00;
      addr_q <= 16'h0000;
      abyte_q <= 1'b0;
      write_enable_latch_q <= 1'b0;
      write_busy_flag_q <= 1'b0;
      wcnt_q <= '0;
      lastwr_q <= 32'h0000_0000;
      miso_q <= 1'b0;
      miso_oe_q <= 1'b0;
      standby_q <= 1'b1;
      sclk_p_q <= 1'b0;
      cs_p_q <= 1'b1;
      hold_p_q <= 1'b1;
    end else begin
      state_q <= state_d;
      sel_q <= sel_d;
      armed_q <= armed_d;
      paused_q <= paused_d;
      bit_q <= bit_d;
      shift_q <= shift_d;
      opcode_q <= opcode_d;
      data_q <= data_d;
      nbytes_q <= nbytes_d;
      addr_q <= addr_d;
      abyte_q <= abyte_d;
      write_enable_latch_q <= write_enable_latch_d;
      write_busy_flag_q <= write_busy_flag_d;
      wcnt_q <= wcnt_d;
      lastwr_q <= lastwr_d;
      miso_q <= miso_d;
      miso_oe_q <= miso_oe_d;
      standby_q <= standby_d;
      sclk_p_q <= pin_s[PIN_SCLK];
      cs_p_q <= pin_s[PIN_CS];
      hold_p_q <= pin_s[PIN_HOLD];
    end
  end

  assign spi_miso = miso_q;
  assign spi_miso_oe = miso_oe_q;
  assign standby = standby_q;

  // Register bus
  logic aw_full_q, aw_full_d, w_full_q, w_full_d;
  logic [31:0] awaddr_q, awaddr_d, wdata_q, wdata_d, rdata_q, rdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
  logic arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;

  always_comb begin
    aw_full_d = aw_full_q;
    w_full_d = w_full_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    rd_byte_d = rd_byte_q;
    if (s_axi_awvalid && awready_q) begin
      aw_full_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q) begin
      w_full_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (aw_full_q && w_full_q && !bvalid_q) begin
      aw_full_d = 1'b0;
      w_full_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = RESP_OKAY;
      if (awaddr_q == ADDR_CTRL) begin
        if (wstrb_q[0]) begin
          rd_byte_d = wdata_q[7:0];
        end
      end else if (awaddr_q != ADDR_STATUS && awaddr_q != ADDR_LASTWR) begin
        bresp_d = RESP_DECERR;
      end
    end
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      case (s_axi_araddr)
        ADDR_CTRL: rdata_d = {24'h000000, rd_byte_q};
        ADDR_STATUS: rdata_d = {20'h00000, standby_q, sel_q, paused_q, pin_s[PIN_WP],
                                status_byte(status_write_lock_bit_q, protect_size_hi_q, protect_size_lo_q,
                                            write_enable_latch_q, write_busy_flag_q)};
        ADDR_LASTWR: rdata_d = lastwr_q;
        default: begin
          rdata_d = 32'h0000_0000;
          rresp_d = RESP_DECERR;
        end
      endcase
    end
    awready_d = !aw_full_d;
    wready_d = !w_full_d;
    arready_d = !rvalid_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= 32'h0000_0000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
      rd_byte_q <= CTRL_RESET;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      arready_q <= 1'b0;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      rd_byte_q <= rd_byte_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      arready_q <= arready_d;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
endmodule

// >>> core/sebi_pkg.sv
package sebi_pkg;

  // Instruction codes
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_RDSR = 8'h05;
  localparam logic [7:0] OP_WRSR = 8'h01;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WRITE = 8'h02;

  // Status byte bit positions
  localparam int SR_WIP = 0;
  localparam int SR_WEL = 1;
  localparam int SR_BP0 = 2;
  localparam int SR_BP1 = 3;
  localparam int SR_STATUS_WRITE_LOCK_BIT = 7;

  // Power-on value of the nonvolatile bits in simulation
  localparam logic NV_INIT = 1'b0;

  // Synchronised pin vector layout
  localparam int PIN_W = 5;
  localparam int PIN_SCLK = 0;
  localparam int PIN_CS = 1;
  localparam int PIN_MOSI = 2;
  localparam int PIN_HOLD = 3;
  localparam int PIN_WP = 4;
  // Select resets low: a stale high from reset must never arm selection
  localparam logic [PIN_W-1:0] PIN_RESET = 5'h18;

  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam int WC_W = 20;

  // Register map
  localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0004;
  localparam logic [31:0] ADDR_LASTWR = 32'h0000_0008;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_OPCODE,
    ST_ADDR,
    ST_DATA,
    ST_SEND,
    ST_EXEC,
    ST_IGNORE
  } sebi_state_t;

endpackage

// >>> core/sebi_sync.sv
`timescale 1ns/1ps
module sebi_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = din;
    sync_d = meta_q;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign dout = sync_q;
endmodule

// >>> tb/sebi_chk.sv
`timescale 1ns/1ps
module sebi_chk #(
  parameter int WRITE_CYCLES = 1000
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_hold_n,
  input wire logic spi_miso,
  input wire logic spi_miso_oe,
  input wire logic standby,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_rvalid
);
  logic armed_q, armed_d;
  int busy_q, busy_d;
  // Armed earlier than the device can be, so the check never outruns it
  always_comb begin
    armed_d = aresetn && (armed_q || spi_cs_n);
    busy_d = (standby || !spi_cs_n) ? 0 : busy_q + 1;
  end
  always_ff @(posedge aclk) begin
    armed_q <= armed_d;
    busy_q <= busy_d;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_release_idle: assert property ($rose(aresetn) |->
    standby && !spi_miso_oe && !s_axi_bvalid && !s_axi_rvalid)
    else $error("device not idle after reset");
  a_unarmed_quiet: assert property (!armed_q && !spi_cs_n |-> standby && !spi_miso_oe)
    else $error("select honoured before a falling select edge");
  a_desel_hiz: assert property (spi_cs_n [*6] |-> !spi_miso_oe)
    else $error("output driven while deselected");
  a_sel_active: assert property ((armed_q && !spi_cs_n) [*6] |-> !standby)
    else $error("standby while selected");
  a_pause_hiz: assert property ($fell(spi_hold_n) && !spi_sclk && !spi_cs_n ##1
    (!spi_hold_n && !spi_cs_n) [*5] |-> !spi_miso_oe)
    else $error("output driven in pause");
  a_shift_on_fall: assert property (spi_miso_oe && $past(spi_miso_oe) && $changed(spi_miso) |->
    !$past(spi_sclk, 2))
    else $error("output changed without a falling clock");
  // A resumed pause re-enables the output with the clock low
  a_oe_after_rise: assert property ($rose(spi_miso_oe) |-> !spi_cs_n &&
    ($past(spi_sclk, 2) || !$past(spi_hold_n, 4)))
    else $error("output enabled away from a rising clock");
  a_standby_desel: assert property ($rose(standby) |-> spi_cs_n && $past(spi_cs_n, 2))
    else $error("standby entered while selected");
  a_write_bound: assert property (busy_q < WRITE_CYCLES + 8)
    else $error("standby deferred too long");
  cover property ($rose(spi_miso_oe));
  cover property ((spi_cs_n && !standby) [*8]);
  cover property ($fell(spi_hold_n) && !spi_cs_n);
endmodule

bind sebi_top sebi_chk #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (.aclk, .aresetn, .spi_sclk, .spi_cs_n,
  .spi_hold_n, .spi_miso, .spi_miso_oe, .standby, .s_axi_bvalid, .s_axi_rvalid);

// >>> tb/sebi_master.sv
`timescale 1ns/1ps
module sebi_master (
  input wire logic aclk,
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_mosi,
  output logic spi_hold_n,
  output logic spi_wp_n,
  input wire logic spi_miso,
  input wire logic spi_miso_oe
);
  localparam time H = 160ns;
  logic pol = 1'b0;
  // Select starts low so the power-up guard gets exercised
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b0;
    spi_mosi = 1'b0;
    spi_hold_n = 1'b1;
    spi_wp_n = 1'b1;
  end
  // Pin changes kept off the rising edge of the sampling clock
  task automatic sel(input logic p);
    @(negedge aclk);
    pol = p;
    spi_sclk = p;
    #H spi_cs_n = 1'b0;
    #H;
  endtask
  task automatic xbit(input logic b, output logic v);
    spi_sclk = 1'b0;
    spi_mosi = b;
    #H spi_sclk = 1'b1;
    // Read late in the high phase, long after the output moved
    #H v = spi_miso_oe ? spi_miso : ~spi_mosi;
  endtask
  task automatic xbyte(input logic [7:0] t, output logic [7:0] v);
    for (int i = 7; i >= 0; i--) xbit(t[i], v[i]);
  endtask
  task automatic desel();
    if (!pol) spi_sclk = 1'b0;
    #H spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi;
    #(2*H);
  endtask
  task automatic pause(input logic on);
    @(negedge aclk);
    spi_sclk = 1'b0;
    #H spi_hold_n = ~on;
    #H;
  endtask
  task automatic protect(input logic v);
    @(negedge aclk);
    spi_wp_n = v;
  endtask
endmodule

// >>> tb/sebi_top_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; $display("unexpected %s: expected %0h, seen %0h", nm, e, g); end end
module sebi_top_tb;
  import sebi_pkg::*;
  localparam int WC = 400;
  logic aclk = 1'b0;
  logic aresetn;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, b;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic spi_sclk, spi_cs_n, spi_mosi, spi_hold_n, spi_wp_n, spi_miso, spi_miso_oe, standby;
  logic [7:0] rx;
  logic [9:0] rows[5] = '{{1'b0, OP_WREN, 1'b1}, {1'b1, OP_WRDI, 1'b0}, {1'b1, OP_WREN, 1'b1},
    {1'b0, OP_WRDI, 1'b0}, {1'b0, OP_WREN, 1'b1}};
  logic [7:0] wq[4] = '{OP_WRITE, 8'h12, 8'h34, 8'hC3};
  int n_fail = 0;
  int checked = 0;
  always #20 aclk = ~aclk;
  sebi_top #(.WRITE_CYCLES(WC)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .spi_sclk, .spi_cs_n,
    .spi_mosi, .spi_hold_n, .spi_wp_n, .spi_miso, .spi_miso_oe, .standby);
  sebi_master m (.aclk, .spi_sclk, .spi_cs_n, .spi_mosi, .spi_hold_n, .spi_wp_n, .spi_miso, .spi_miso_oe);
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] v, input logic [3:0] s);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [31:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic frame(input logic p, input logic [7:0] q[$]);
    m.sel(p);
    foreach (q[i]) m.xbyte(q[i], rx);
    m.desel();
  endtask
  task automatic st(input logic [7:0] e);
    axi_rd(ADDR_STATUS);
    `CHK("status", e, d[7:0])
  endtask
  task automatic settle();
    for (int i = 0; i < 2 * WC && !standby; i++) @(posedge aclk);
  endtask
  task automatic fin(input string s);
    $display("test %s over", s);
  endtask
  task automatic complete_run();
    $display("checked %0d, n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #2ms;
    n_fail++;
    complete_run();
  end
  initial begin
    aresetn <= 1'b0;
    s_axi_awaddr <= '0;
    s_axi_wdata <= '0;
    s_axi_wstrb <= 4'h0;
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_bready <= 1'b0;
    s_axi_araddr <= '0;
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK("standby", 1'b1, standby)
    axi_rd(ADDR_CTRL);
    `CHK("ctrl", {24'h0, CTRL_RESET}, d)
    // Select was low through reset, so this byte must be dropped
    frame(1'b0, '{OP_WREN});
    axi_rd(ADDR_STATUS);
    `CHK("status word", 32'h0000_0900, d)
    fin("power-up");
    foreach (rows[i]) begin
      frame(rows[i][9], '{rows[i][8:1]});
      frame(rows[i][9], '{OP_RDSR, 8'h00});
      `CHK("rdsr", {6'h0, rows[i][0], 1'b0}, rx)
      st({6'h0, rows[i][0], 1'b0});
    end
    frame(1'b0, '{8'hAA, OP_WRDI});
    st(8'h02);
    frame(1'b1, '{OP_WRDI, 8'h00});
    st(8'h02);
    fin("commands");
    m.sel(1'b0);
    for (int i = 7; i >= 4; i--) m.xbit(OP_WRDI[i], b);
    m.pause(1'b1);
    repeat (3) m.xbit(1'b1, b);
    axi_rd(ADDR_STATUS);
    `CHK("paused", 1'b1, d[9])
    `CHK("oe in pause", 1'b0, spi_miso_oe)
    m.pause(1'b0);
    for (int i = 3; i >= 0; i--) m.xbit(OP_WRDI[i], b);
    m.desel();
    st(8'h00);
    frame(1'b0, '{OP_WREN});
    // Pause in the middle of a status read, then finish the byte
    m.sel(1'b0);
    m.xbyte(OP_RDSR, rx);
    for (int i = 7; i >= 4; i--) m.xbit(1'b0, rx[i]);
    m.pause(1'b1);
    `CHK("oe in read pause", 1'b0, spi_miso_oe)
    m.pause(1'b0);
    for (int i = 3; i >= 0; i--) m.xbit(1'b0, rx[i]);
    m.desel();
    `CHK("resumed read", 8'h02, rx)
    m.sel(1'b0);
    m.xbyte(OP_WRDI, rx);
    m.pause(1'b1);
    m.desel();
    m.pause(1'b0);
    st(8'h02);
    m.sel(1'b0);
    foreach (wq[i]) m.xbyte(wq[i], rx);
    m.pause(1'b1);
    m.desel();
    m.pause(1'b0);
    `CHK("standby", 1'b0, standby)
    frame(1'b0, '{OP_RDSR, 8'h00});
    `CHK("rdsr busy", 8'h03, rx)
    settle();
    axi_rd(ADDR_LASTWR);
    `CHK("last write", 32'h01C3_1234, d)
    st(8'h00);
    fin("pause");
    frame(1'b0, '{OP_WREN});
    frame(1'b0, '{OP_WRSR, 8'h8C});
    settle();
    st(8'h8C);
    // Second reset: latch cleared, nonvolatile bits kept
    frame(1'b0, '{OP_WREN});
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    st(8'h8C);
    // Changed only between frames
    m.protect(1'b0);
    frame(1'b1, '{OP_WREN});
    frame(1'b1, '{OP_WRSR, 8'h00});
    settle();
    axi_rd(ADDR_STATUS);
    `CHK("locked", 7'h23, {d[8], d[7:2]})
    m.protect(1'b1);
    frame(1'b0, '{OP_WREN});
    frame(1'b0, '{OP_WRSR, 8'h00});
    settle();
    st(8'h00);
    fin("protect");
    axi_wr(ADDR_CTRL, 32'h0000_00A5, 4'hF);
    frame(1'b1, '{OP_READ, 8'h00, 8'h00, 8'h00});
    `CHK("read byte", 8'hA5, rx)
    axi_wr(ADDR_CTRL, 32'h0000_005A, 4'hE);
    axi_rd(ADDR_CTRL);
    `CHK("ctrl strobe", {24'h0, 8'hA5}, d)
    axi_rd(32'h0000_0010);
    `CHK("unmapped rd", {RESP_DECERR, 32'h0}, {r, d})
    axi_wr(32'h0000_0010, 32'h0000_00FF, 4'hF);
    `CHK("unmapped wr", RESP_DECERR, r)
    fin("registers");
    complete_run();
  end
endmodule
